// ### rtl/burst_seq_cfg.svh
// timing, field positions and encodings for the burst sequencer
`ifndef BURST_SEQ_CFG_SVH
`define BURST_SEQ_CFG_SVH
`define MODE_BL_LSB        0
`define MODE_BL_MSB        2
`define MODE_BT_BIT        3
`define MODE_CL_LSB        4
`define MODE_CL_MSB        6
`define MODE_OP_LO_BIT     7
`define MODE_OP_HI_BIT     8
`define MODE_WB_BIT        9
`define MODE_WIDE_BIT      11
`define MODE_RESET         12'h022
`define BL_ONE             3'h0
`define BL_TWO             3'h1
`define BL_FOUR            3'h2
`define BL_EIGHT           3'h3
`define BL_PAGE            3'h7
`define CL_ONE             3'h1
`define CL_TWO             3'h2
`define CL_THREE           3'h3
`define PAGE_WRITE_LEN     9'h008
`define CONFIG_READ_LOC    12'h004
`define PAGE_LEN           9'h100
`endif

// ### rtl/burst_seq_pkg.sv
// types shared by the burst sequencer files
package burst_seq_pkg;
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_read  = 3'b010,
        st_write = 3'b100
    } burst_state_t;
    typedef logic [7:0]  column_t;
    typedef logic [11:0] mode_word_t;
endpackage : burst_seq_pkg

// ### rtl/burst_sequencer.sv
// burst column sequencer with read latency and write burst policy
`timescale 1ns/1ps
`default_nettype none
`include "burst_seq_cfg.svh"
module burst_sequencer #(
    parameter bit WIDE_X16 = 1'b1
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      mode_load,
    input  wire burst_seq_pkg::mode_word_t mode_in,
    input  wire logic                      read_cmd,
    input  wire logic                      write_cmd,
    input  wire logic                      terminate,
    input  wire logic                      config_read,
    input  wire burst_seq_pkg::column_t    start_column,
    output var  burst_seq_pkg::column_t    access_column,
    output var  logic                      access_valid,
    output var  logic                      access_is_write,
    output var  logic                      data_drive,
    output var  logic                      data_valid,
    output var  burst_seq_pkg::mode_word_t mode_readback,
    output var  logic                      normal_mode,
    output var  logic                      last_access
);
    import burst_seq_pkg::*;

    typedef struct packed {
        mode_word_t   mode;
        burst_state_t state;
        column_t      base;
        column_t      first;
        logic [8:0]   count;
        logic [8:0]   length;
        logic [7:0]   mask;
        logic         order_il;
        column_t      column;
        logic         valid;
        logic         is_write;
        logic         drive;
        logic         dvalid;
        logic         last;
        mode_word_t   readback;
        logic         normal;
    } seq_state_t;

    seq_state_t cur;
    seq_state_t next_cur;
    logic       read_go;
    logic       pipe_drive;
    logic       pipe_go;

    // length field to number of accesses
    function automatic logic [8:0] burst_len(input logic [2:0] field);
        unique case (field)
            `BL_ONE:   burst_len = 9'h001;
            `BL_TWO:   burst_len = 9'h002;
            `BL_FOUR:  burst_len = 9'h004;
            `BL_EIGHT: burst_len = 9'h008;
            `BL_PAGE:  burst_len = `PAGE_LEN;
            default:   burst_len = 9'h001;
        endcase
    endfunction : burst_len

    // write length under the write burst policy bit
    function automatic logic [8:0] write_len(input mode_word_t m);
        if (m[`MODE_WB_BIT]) begin
            write_len = 9'h001;
        end else if (m[`MODE_BL_MSB:`MODE_BL_LSB] == `BL_PAGE) begin
            write_len = `PAGE_WRITE_LEN;
        end else begin
            write_len = burst_len(m[`MODE_BL_MSB:`MODE_BL_LSB]);
        end
    endfunction : write_len

    // offset mask of the block selected by a length
    function automatic logic [7:0] block_mask(input logic [8:0] len);
        block_mask = 8'(len - 9'h001);
    endfunction : block_mask

    // delays the read data start by the programmed latency
    read_latency_pipe u_latency (
        .clock       (clock),
        .rst         (rst),
        .start       (read_go),
        .latency     (cur.mode[`MODE_CL_MSB:`MODE_CL_LSB]),
        .drive_early (pipe_drive),
        .data_go     (pipe_go)
    );

    assign read_go = cur.normal && read_cmd && !write_cmd && cur.state == st_idle;

    // next state: mode load, burst start, stepping and termination
    always_comb begin
        logic [7:0] off;
        logic [7:0] k;
        logic [8:0] len;
        off = '0;
        k = '0;
        len = '0;
        next_cur = cur;
        next_cur.valid = 1'b0;
        next_cur.last = 1'b0;
        next_cur.drive = pipe_drive || (cur.drive && !cur.last);
        next_cur.dvalid = pipe_go;
        if (mode_load && cur.state == st_idle) begin
            next_cur.mode = mode_in;
            if (!WIDE_X16) begin
                next_cur.mode[`MODE_WIDE_BIT] = 1'b0;
            end
        end
        next_cur.normal = (next_cur.mode[`MODE_OP_HI_BIT:`MODE_OP_LO_BIT] == 2'b00);
        if (config_read) begin
            next_cur.readback = cur.mode;
        end
        unique case (cur.state)
            st_idle: begin
                if (cur.normal && (read_cmd || write_cmd)) begin
                    len = write_cmd ? write_len(cur.mode)
                                    : burst_len(cur.mode[`MODE_BL_MSB:`MODE_BL_LSB]);
                    next_cur.length = len;
                    next_cur.mask = block_mask(len);
                    next_cur.base = start_column & ~block_mask(len);
                    next_cur.first = start_column & block_mask(len);
                    // page reads and single accesses ignore the order bit; page writes run 8 long and use it
                    next_cur.order_il = cur.mode[`MODE_BT_BIT] && len != `PAGE_LEN
                                        && len != 9'h001;
                    next_cur.count = 9'h000;
                    next_cur.is_write = write_cmd;
                    next_cur.state = write_cmd ? st_write : st_read;
                end
            end
            st_read, st_write: begin
                if (cur.state == st_read && !cur.dvalid && cur.count == 9'h000) begin
                    // waiting for the latency pipe to release the first access
                    if (pipe_go) begin
                        k = '0;
                    end
                end
                if (terminate) begin
                    next_cur.state = st_idle;
                    next_cur.drive = pipe_drive;
                end else if (cur.state == st_write || pipe_go || cur.count != 9'h000) begin
                    k = cur.count[7:0];
                    off = cur.order_il ? (cur.first ^ k)
                                       : 8'((cur.first + k)) & cur.mask;
                    next_cur.column = cur.base | (off & cur.mask);
                    next_cur.valid = 1'b1;
                    next_cur.count = cur.count + 9'h001;
                    if (cur.count + 9'h001 == cur.length) begin
                        next_cur.last = 1'b1;
                        next_cur.state = st_idle;
                    end
                end
            end
            default: next_cur.state = st_idle;
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            cur <= '0;
            cur.mode <= `MODE_RESET;
            cur.state <= st_idle;
            cur.normal <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state flip-flops
    assign access_column   = cur.column;
    assign access_valid    = cur.valid;
    assign access_is_write = cur.is_write;
    assign data_drive      = cur.drive;
    assign data_valid      = cur.dvalid;
    assign mode_readback   = cur.readback;
    assign normal_mode     = cur.normal;
    assign last_access     = cur.last;

    // command takes and mode fields, shared by the checks below
    logic       take_read;
    logic       take_write;
    logic [2:0] bl_now;
    logic [2:0] cl_now;
    assign take_read  = read_go;
    assign take_write = cur.normal && write_cmd && cur.state == st_idle;
    assign bl_now     = cur.mode[`MODE_BL_MSB:`MODE_BL_LSB];
    assign cl_now     = cur.mode[`MODE_CL_MSB:`MODE_CL_LSB];

    // block selection and start column per burst length
    chk_single_col: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_ONE)
        |=> cur.base == $past(start_column) && cur.mask == 8'h00 && !cur.order_il)
        else $error("single burst column wrong");

    chk_two_block: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_TWO)
        |=> cur.base == {$past(start_column[7:1]), 1'b0}
            && cur.first == {7'h00, $past(start_column[0])})
        else $error("two block wrong");

    chk_four_block: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_FOUR)
        |=> cur.base == {$past(start_column[7:2]), 2'b00}
            && cur.first == {6'h00, $past(start_column[1:0])})
        else $error("four block wrong");

    chk_eight_block: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_EIGHT)
        |=> cur.base == {$past(start_column[7:3]), 3'b000}
            && cur.first == {5'h00, $past(start_column[2:0])})
        else $error("eight block wrong");

    chk_page_start: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_PAGE)
        |=> cur.base == 8'h00 && cur.first == $past(start_column)
            && !cur.order_il)
        else $error("page start wrong");

    // access order inside the block
    chk_in_block: assert property (@(posedge clock) disable iff (rst)
        access_valid |-> (access_column & ~cur.mask) == cur.base)
        else $error("burst left its block");

    chk_seq_step: assert property (@(posedge clock) disable iff (rst)
        (access_valid && !cur.order_il && !last_access && cur.state != st_idle && !terminate)
        |=> access_column == (($past(access_column) + 8'h01) & cur.mask | cur.base))
        else $error("sequential step wrong");

    chk_seq_wrap: assert property (@(posedge clock) disable iff (rst)
        (access_valid && !cur.order_il && (access_column & cur.mask) == cur.mask
            && !last_access && cur.state != st_idle && !terminate)
        |=> (access_column & cur.mask) == 8'h00)
        else $error("sequential wrap wrong");

    chk_il_step: assert property (@(posedge clock) disable iff (rst)
        (access_valid && cur.order_il && !last_access && cur.state != st_idle && !terminate)
        |=> access_column == (cur.base | ((cur.first ^ $past(cur.count[7:0])) & cur.mask)))
        else $error("interleaved step wrong");

    // write lengths under the policy bit, then read length decode
    chk_write_len: assert property (@(posedge clock) disable iff (rst)
        (cur.state == st_write) |-> cur.length <= 9'h008)
        else $error("write burst too long");

    chk_wb_single: assert property (@(posedge clock) disable iff (rst)
        (take_write && cur.mode[`MODE_WB_BIT]) |=> cur.length == 9'h001)
        else $error("write policy not single");

    chk_write_burst: assert property (@(posedge clock) disable iff (rst)
        (take_write && !cur.mode[`MODE_WB_BIT] && bl_now == `BL_EIGHT) |=> cur.length == 9'h008)
        else $error("write burst length wrong");

    chk_page_write: assert property (@(posedge clock) disable iff (rst)
        (take_write && !cur.mode[`MODE_WB_BIT] && bl_now == `BL_PAGE) |=> cur.length == 9'h008)
        else $error("page write not eight");

    chk_len_four: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_FOUR) |=> cur.length == 9'h004)
        else $error("length four decode wrong");

    chk_len_eight: assert property (@(posedge clock) disable iff (rst)
        (take_read && bl_now == `BL_EIGHT) |=> cur.length == 9'h008)
        else $error("length eight decode wrong");

    // latency and data drive, seen one edge after they are registered
    chk_lat_one: assert property (@(posedge clock) disable iff (rst)
        (take_read && cl_now == `CL_ONE && !mode_load) |-> ##2 data_valid)
        else $error("latency one data late");

    chk_lat_two: assert property (@(posedge clock) disable iff (rst)
        (take_read && cl_now == `CL_TWO && !mode_load) |-> ##3 data_valid)
        else $error("latency two data late");

    chk_lat_three: assert property (@(posedge clock) disable iff (rst)
        (take_read && cl_now == `CL_THREE && !mode_load) |-> ##4 data_valid)
        else $error("latency three data late");

    chk_drive_one: assert property (@(posedge clock) disable iff (rst)
        (take_read && cl_now == `CL_ONE && !mode_load) |=> data_drive)
        else $error("latency one drive late");

    chk_drive_two: assert property (@(posedge clock) disable iff (rst)
        (take_read && cl_now == `CL_TWO && !mode_load) |-> ##2 data_drive)
        else $error("latency two drive late");

    chk_drive_early: assert property (@(posedge clock) disable iff (rst)
        $rose(data_valid) |-> data_drive)
        else $error("data valid without drive");

    // mode word, readback and operating mode
    chk_readback: assert property (@(posedge clock) disable iff (rst)
        config_read |=> mode_readback == $past(cur.mode))
        else $error("readback differs from mode");

    chk_narrow_bit: assert property (@(posedge clock) disable iff (rst)
        !WIDE_X16 |-> cur.mode[`MODE_WIDE_BIT] == 1'b0)
        else $error("wide-only bit kept");

    chk_normal_flag: assert property (@(posedge clock) disable iff (rst)
        normal_mode == (cur.mode[`MODE_OP_HI_BIT:`MODE_OP_LO_BIT] == 2'b00))
        else $error("normal flag wrong");

    chk_normal_only: assert property (@(posedge clock) disable iff (rst)
        (!cur.normal && cur.state == st_idle) |=> cur.state == st_idle)
        else $error("burst in non-normal mode");

    // burst count and termination
    chk_write_start: assert property (@(posedge clock) disable iff (rst)
        (take_write ##1 !terminate) |=> access_valid && access_is_write)
        else $error("write access late");

    chk_last_count: assert property (@(posedge clock) disable iff (rst)
        last_access |-> cur.count == cur.length)
        else $error("burst count wrong");

    chk_term_stop: assert property (@(posedge clock) disable iff (rst)
        (terminate && cur.state != st_idle) |=> !access_valid && cur.state == st_idle)
        else $error("terminate ignored");

    chk_term_drive: assert property (@(posedge clock) disable iff (rst)
        (terminate && cur.state != st_idle && !pipe_drive) |=> !data_drive)
        else $error("drive held after terminate");

    // main scenarios
    cov_read: cover property (@(posedge clock) read_go);
    cov_write: cover property (@(posedge clock) last_access && access_is_write);
    cov_il: cover property (@(posedge clock) access_valid && cur.order_il);
    cov_page_wrap: cover property (@(posedge clock) access_valid && cur.length == `PAGE_LEN
        && access_column == 8'h00);
    cov_terminate: cover property (@(posedge clock) terminate && cur.state != st_idle);
endmodule : burst_sequencer
`default_nettype wire

// ### rtl/read_latency_pipe.sv
// read latency pipe: delays a read start by one to three clocks
`timescale 1ns/1ps
`default_nettype none
`include "burst_seq_cfg.svh"
module read_latency_pipe (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [2:0] latency,
    output var  logic       drive_early,
    output var  logic       data_go
);
    import burst_seq_pkg::*;
    typedef struct packed {
        logic [2:0] taps;
    } pipe_state_t;
    pipe_state_t cur;
    pipe_state_t next_cur;
    // shift register of pending read starts
    always_comb begin
        next_cur.taps = {cur.taps[1:0], start};
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    // drive one edge before valid data; latency one drives immediately
    always_comb begin
        unique case (latency)
            `CL_ONE:   begin drive_early = start;       data_go = cur.taps[0]; end
            `CL_TWO:   begin drive_early = cur.taps[0]; data_go = cur.taps[1]; end
            default:   begin drive_early = cur.taps[1]; data_go = cur.taps[2]; end
        endcase
    end
endmodule : read_latency_pipe
`default_nettype wire

// ### sim/burst_sequencer_tb.sv
// self-checking bench for the burst sequencer
`timescale 1ns/1ps
`default_nettype none
`include "burst_seq_cfg.svh"
module burst_sequencer_tb;
    import burst_seq_pkg::*;
    typedef struct {
        logic [2:0] bl; logic bt; logic [2:0] cl; logic wb; logic wr; column_t col;
    } row_t;
    logic       clock, rst, mode_load, terminate, config_read, go, go_write;
    logic       read_cmd, write_cmd, access_valid, access_is_write;
    logic       data_drive, data_valid, normal_mode, last_access;
    mode_word_t mode_in, mode_readback;
    column_t    go_column, start_column, access_column;
    int         n_errors, check_count, n;
    // ordinary bursts: length, order, latency, policy, direction, column
    row_t rows [10] = '{
        '{`BL_TWO,   1'b0, `CL_ONE,   1'b0, 1'b0, 8'h05},
        '{`BL_FOUR,  1'b0, `CL_TWO,   1'b0, 1'b1, 8'h31},
        '{`BL_FOUR,  1'b1, `CL_THREE, 1'b0, 1'b0, 8'h33},
        '{`BL_EIGHT, 1'b0, `CL_TWO,   1'b0, 1'b0, 8'hFE},
        '{`BL_EIGHT, 1'b1, `CL_ONE,   1'b0, 1'b1, 8'h45},
        '{`BL_ONE,   1'b1, `CL_THREE, 1'b0, 1'b0, 8'hA7},
        '{`BL_PAGE,  1'b0, `CL_TWO,   1'b0, 1'b0, 8'hFD},
        '{`BL_EIGHT, 1'b0, `CL_TWO,   1'b1, 1'b1, 8'h13},
        '{`BL_PAGE,  1'b0, `CL_ONE,   1'b0, 1'b1, 8'h10},
        '{`BL_TWO,   1'b1, `CL_THREE, 1'b0, 1'b1, 8'h00}
    };
    burst_sequencer dut_u (.clock(clock), .rst(rst), .mode_load(mode_load),
        .mode_in(mode_in), .read_cmd(read_cmd), .write_cmd(write_cmd),
        .terminate(terminate), .config_read(config_read), .start_column(start_column),
        .access_column(access_column), .access_valid(access_valid),
        .access_is_write(access_is_write), .data_drive(data_drive), .data_valid(data_valid),
        .mode_readback(mode_readback), .normal_mode(normal_mode), .last_access(last_access));
    ctrl_model ctrl_u (.clock(clock), .go(go), .go_write(go_write), .go_column(go_column),
        .read_cmd(read_cmd), .write_cmd(write_cmd), .start_column(start_column));
    // clock and hang watchdog
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock; // cycle-level model, latency counted in clocks
    end
    initial begin
        #20000;
        n_errors++;
        end_sim();
    end
    task automatic end_sim();
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    function automatic int blen(row_t r);
        int len;
        len = (r.bl == `BL_PAGE) ? 256 : (1 << r.bl);
        if (r.wr) len = r.wb ? 1 : ((r.bl == `BL_PAGE) ? 8 : len);
        return len;
    endfunction : blen
    function automatic column_t ecol(row_t r, int k);
        int len;
        column_t off;
        len = blen(r);
        if (len == 256) return r.col + k[7:0];
        off = r.col & column_t'(len - 1);
        return (r.col & ~column_t'(len - 1)) | (r.bt ? off ^ k[7:0] : column_t'((off + k) % len));
    endfunction : ecol
    task automatic set_mode(input mode_word_t m);
        @(posedge clock);
        mode_load <= 1'b1;
        mode_in   <= m;
        @(posedge clock);
        mode_load <= 1'b0;
    endtask : set_mode
    task automatic issue(input logic w, input column_t c);
        @(posedge clock);
        go        <= 1'b1;
        go_write  <= w;
        go_column <= c;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
    endtask : issue
    task automatic run(input row_t r);
        int t;
        n = 0;
        set_mode({2'b00, r.wb, 2'b00, r.cl, r.bt, r.bl});
        issue(r.wr, r.col);
        for (t = 0; t < 300; t++) begin
            if (!r.wr && t == r.cl - 1) chk("data_drive", data_drive, 1);
            if (access_valid === 1'b1) begin
                if (n == 0) chk("first_access", t, r.wr ? 1 : r.cl);
                if (n == 0 && !r.wr) chk("data_valid", data_valid, 1);
                chk("column", access_column, ecol(r, n));
                chk("is_write", access_is_write, r.wr);
                n++;
                if (last_access === 1'b1) break;
            end
            @(posedge clock);
            #1;
        end
        chk("count", n, blen(r));
    endtask : run
    // reset, table loop, then readback, refusal, termination and reset cases
    initial begin
        {rst, mode_load, terminate, config_read, go, go_write} = 6'h21;
        mode_in   = 12'h000;
        go_column = 8'h00;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        chk("normal_mode", normal_mode, 1);
        foreach (rows[i]) run(rows[i]);
        set_mode(12'hA23);
        @(posedge clock);
        config_read <= 1'b1;
        @(posedge clock);
        config_read <= 1'b0;
        @(posedge clock);
        #1;
        chk("readback", mode_readback, 12'hA23);
        set_mode(12'h0A2);
        issue(1'b0, 8'h10);
        n = 0;
        repeat (10) begin
            n += (access_valid === 1'b1);
            @(posedge clock);
            #1;
        end
        chk("test_mode", normal_mode, 0);
        chk("refused", n, 0);
        set_mode(12'h027);
        issue(1'b0, 8'h00);
        repeat (5) @(posedge clock);
        terminate <= 1'b1;
        @(posedge clock);
        terminate <= 1'b0;
        n = 0;
        repeat (20) begin
            @(posedge clock);
            #1;
            n += (access_valid === 1'b1);
        end
        chk("terminated", n, 0);
        chk("term_drive", data_drive, 0);
        issue(1'b0, 8'h40);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        config_read <= 1'b1;
        @(posedge clock);
        config_read <= 1'b0;
        @(posedge clock);
        #1;
        chk("reset_access", access_valid, 0);
        chk("reset_mode", mode_readback, `MODE_RESET);
        end_sim();
    end
endmodule : burst_sequencer_tb
`default_nettype wire

// ### sim/ctrl_model.sv
// controller model: issues read and write commands with their column
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
    input  wire logic                   clock,
    input  wire logic                   go,
    input  wire logic                   go_write,
    input  wire burst_seq_pkg::column_t go_column,
    output var  logic                   read_cmd = 1'b0,
    output var  logic                   write_cmd = 1'b0,
    output var  burst_seq_pkg::column_t start_column = 8'h00
);
    import burst_seq_pkg::*;
    // one-cycle command, column alongside; released address toggles
    always_ff @(posedge clock) begin
        read_cmd     <= go & ~go_write;
        write_cmd    <= go & go_write;
        start_column <= go ? go_column : ~start_column;
    end
endmodule : ctrl_model
`default_nettype wire
